//--- dram_ctl_pkg.sv
// Purpose: constants and types for the 1M x 1 page-mode memory controller
// Assumes: 50 MHz ref_clk_i, one speed grade of timing below
// Notes:   times in ns/us/ms, cycle counts derived from the clock period
// Behaviour
// - Cell address travels over ten shared pins as row then column half.
// - Controller presents row first, then column, each latched by its strobe.
// - Controller holds row stable by row fall, column by column fall.
// - Early write: write strobe before column strobe; data timed to column.
// - Delayed or read-modify-write: write strobe after column; data timed to it.
// - Controller refreshes all 512 rows within every 64 ms.
// - After power-up: strobes high 200 us, then eight refresh cycles.
// - Row-only refresh: row strobe low, column strobe high, output off. Controller never uses it; it refreshes column before row.
package dram_ctl_pkg;
   localparam int CLK_PERIOD_NS   = 20;
   localparam int ADDR_W          = 10;
   localparam int CELL_ADDR_W     = 20;
   localparam int REFRESH_ROWS    = 512;
   localparam int REFRESH_MS      = 64;
   localparam int POWERUP_US      = 200;
   localparam int INIT_CYCLES     = 8;
   localparam int T_RP_NS         = 70;
   localparam int T_RCD_NS        = 25;
   localparam int T_RAH_NS        = 15;
   localparam int T_RAC_NS        = 100;
   localparam int T_CAS_NS        = 25;
   localparam int T_RAS_NS        = 100;
   localparam int T_DH_NS         = 15;
   localparam int T_CSR_NS        = 0;
   localparam int T_CHR_NS        = 15;
   // least times round up
   localparam int RP_CYC   = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RCD_CYC  = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RAH_CYC  = (T_RAH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RAC_CYC  = (T_RAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int CAS_CYC  = (T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RAS_CYC  = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CHR_CYC  = (T_CHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CSR_CYC  = (T_CSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   // longest time rounds down
   localparam int REF_INTERVAL_CYC =
      (REFRESH_MS * 1000000 / CLK_PERIOD_NS) / REFRESH_ROWS;
   localparam int POWERUP_CYC = POWERUP_US * 1000 / CLK_PERIOD_NS;

   typedef enum logic [7:0] {
      ST_POWERUP = 8'h01,
      ST_IDLE    = 8'h02,
      ST_ROW     = 8'h04,
      ST_COL     = 8'h08,
      ST_CAS     = 8'h10,
      ST_PRE     = 8'h20,
      ST_CBR     = 8'h40,
      ST_CBR_RAS = 8'h80
   } ctl_state_t;

   typedef struct packed {
      logic                   write;
      logic                   page;
      logic [CELL_ADDR_W-1:0] addr;
      logic                   wdata;
   } mem_req_t;

   typedef struct packed {
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [ADDR_W-1:0] multiplexed_address;
      logic din;
   } dram_pins_t;
endpackage

//--- cycle_timer.sv
// Purpose: loadable down counter for strobe phase timing
// Assumes: load has priority over counting
// Notes:   done_o is high while the count is zero
`timescale 1ns/100ps
module cycle_timer #(
   parameter int WIDTH = 8
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] value_i,
   output logic                  done_o
);
   logic [WIDTH-1:0] count_r;

   initial begin
      if (WIDTH < 2) begin
         $error("cycle_timer width too small");
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_r <= '0;
      end else if (load_i) begin
         count_r <= value_i;
      end else if (count_r != '0) begin
         count_r <= count_r - 1'b1;
      end
   end

   assign done_o = (count_r == '0);
endmodule

//--- dram_ctl.sv
// Purpose: controller driving a 1M x 1 page-mode memory over its strobes
// Assumes: single 50 MHz clock; one request at a time from user logic
// Notes:   uses early write only, so data pins may share one wire
`timescale 1ns/100ps
module dram_ctl
   import dram_ctl_pkg::*;
#(
   parameter int POWERUP_CYCLES = POWERUP_CYC,
   parameter int REF_CYCLES     = REF_INTERVAL_CYC
) (
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   input  wire mem_req_t   req_i,
   input  wire logic       req_valid_i,
   output logic            req_ready_o,
   output logic            rdata_o,
   output logic            rdata_valid_o,
   output dram_pins_t      pins_o,
   input  wire logic       dout_i
);
   localparam int TW = 24;
   localparam logic [TW-1:0] POWERUP_LD = TW'(POWERUP_CYCLES - 1);
   localparam logic [TW-1:0] REF_LD     = TW'(REF_CYCLES - 1);
   localparam logic [TW-1:0] RP_LD      = TW'(RP_CYC - 1);
   localparam logic [TW-1:0] RAH_LD     = TW'(RAH_CYC - 1);
   localparam logic [TW-1:0] RAC_LD     = TW'(RAC_CYC - 1);
   localparam logic [TW-1:0] RAS_LD     = TW'(RAS_CYC - 1);
   localparam logic [TW-1:0] CSR_LD     = TW'(CSR_CYC - 1);
   localparam logic [3:0]    INIT_LAST  = 4'(INIT_CYCLES);

   initial begin
      if (POWERUP_CYCLES < 2 || REF_CYCLES < 16) begin
         $error("dram_ctl timing parameters too small");
      end
      if (POWERUP_CYCLES >= (1 << TW) || REF_CYCLES >= (1 << TW)) begin
         $error("dram_ctl timer too narrow");
      end
   end

   ctl_state_t state_r;
   dram_pins_t pins_r;
   mem_req_t   cur_r;
   logic       ready_r;
   logic       rdata_r;
   logic       rvalid_r;
   logic [3:0] init_cnt_r;
   logic       ref_due_r;
   logic [TW-1:0] ref_cnt_r;
   logic [TW-1:0] pwr_cnt_r;
   logic       dout_s1_r;
   logic       dout_s2_r;
   logic       tmr_load;
   logic [TW-1:0] tmr_val;
   logic       tmr_done;
   logic       take_req;
   logic       ref_tick;

   cycle_timer #(.WIDTH(TW)) u_timer (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .load_i    (tmr_load),
      .value_i   (tmr_val),
      .done_o    (tmr_done)
   );

   // data-out is asynchronous to our clock
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dout_s1_r <= 1'b0;
         dout_s2_r <= 1'b0;
      end else begin
         dout_s1_r <= dout_i;
         dout_s2_r <= dout_s1_r;
      end
   end

   // refresh pacing: one row per interval covers all rows in time
   assign ref_tick = (ref_cnt_r == '0);
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_cnt_r <= '0;
      end else if (ref_tick) begin
         ref_cnt_r <= REF_LD;
      end else begin
         ref_cnt_r <= ref_cnt_r - 1'b1;
      end
   end

   // power-up pause: strobes stay high while this counts down
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pwr_cnt_r <= POWERUP_LD;
      end else if (state_r == ST_POWERUP && pwr_cnt_r != '0) begin
         pwr_cnt_r <= pwr_cnt_r - 1'b1;
      end
   end

   // set wins over the clear taken when a refresh starts
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_due_r <= 1'b0;
      end else if (ref_tick) begin
         ref_due_r <= 1'b1;
      end else if (state_r == ST_CBR && tmr_done) begin
         ref_due_r <= 1'b0;
      end
   end

   assign take_req = ready_r && req_valid_i;

   // timer loads on each state change except those into ST_IDLE
   always_comb begin
      tmr_load = 1'b0;
      tmr_val  = '0;
      case (state_r)
         ST_IDLE: begin
            if (take_req) begin
               tmr_load = 1'b1;
               tmr_val  = RAH_LD;
            end else if (ref_due_r || init_cnt_r != INIT_LAST) begin
               tmr_load = 1'b1;
               tmr_val  = CSR_LD;
            end
         end
         ST_ROW: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               tmr_val  = RAC_LD;
            end
         end
         ST_COL: begin
            tmr_load = 1'b1;
            tmr_val  = RAC_LD;
         end
         ST_CAS: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               tmr_val  = RP_LD;
            end
         end
         ST_CBR: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               tmr_val  = RAS_LD;
            end
         end
         ST_CBR_RAS: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               tmr_val  = RP_LD;
            end
         end
         default: begin
            tmr_load = 1'b0;
         end
      endcase
   end

   // main sequencer and pin drive
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r    <= ST_POWERUP;
         pins_r     <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                         multiplexed_address: '0, din: 1'b0};
         cur_r      <= '0;
         ready_r    <= 1'b0;
         init_cnt_r <= 4'h0;
      end else begin
         case (state_r)
            ST_POWERUP: begin
               if (pwr_cnt_r == '0) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               // a request seen with ready high is always taken; a due
               // refresh waits for the next idle cycle
               if (take_req) begin
                  ready_r      <= 1'b0;
                  cur_r        <= req_i;
                  pins_r.multiplexed_address <=
                     req_i.addr[CELL_ADDR_W-1:ADDR_W];
                  pins_r.ras_n <= 1'b0;
                  pins_r.we_n  <= ~req_i.write;
                  pins_r.din   <= req_i.wdata;
                  state_r      <= ST_ROW;
               end else if (ref_due_r || init_cnt_r != INIT_LAST) begin
                  ready_r      <= 1'b0;
                  pins_r.cas_n <= 1'b0;
                  pins_r.we_n  <= 1'b1;
                  state_r      <= ST_CBR;
               end else begin
                  ready_r <= 1'b1;
               end
            end
            ST_ROW: begin
               if (tmr_done) begin
                  pins_r.multiplexed_address <=
                     cur_r.addr[ADDR_W-1:0];
                  state_r <= ST_COL;
               end
            end
            ST_COL: begin
               // column fall strobes data for early write
               pins_r.cas_n <= 1'b0;
               state_r      <= ST_CAS;
            end
            ST_CAS: begin
               if (tmr_done) begin
                  pins_r.cas_n <= 1'b1;
                  pins_r.ras_n <= 1'b1;
                  pins_r.we_n  <= 1'b1;
                  state_r      <= ST_PRE;
               end
            end
            ST_PRE: begin
               if (tmr_done) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_CBR: begin
               if (tmr_done) begin
                  pins_r.ras_n <= 1'b0;
                  state_r      <= ST_CBR_RAS;
               end
            end
            ST_CBR_RAS: begin
               if (tmr_done) begin
                  pins_r.ras_n <= 1'b1;
                  pins_r.cas_n <= 1'b1;
                  if (init_cnt_r != INIT_LAST) begin
                     init_cnt_r <= init_cnt_r + 4'h1;
                  end
                  state_r <= ST_PRE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // read data sampled after the row access time has passed
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r  <= 1'b0;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= 1'b0;
         if (state_r == ST_CAS && tmr_done && !cur_r.write) begin
            rdata_r  <= dout_s2_r;
            rvalid_r <= 1'b1;
         end
      end
   end

   assign req_ready_o   = ready_r;
   assign rdata_o       = rdata_r;
   assign rdata_valid_o = rvalid_r;
   assign pins_o        = pins_r;

   sequence s_cas_fall;
      $fell(pins_r.cas_n) && !pins_r.ras_n;
   endsequence

   a_row_before_col: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      s_cas_fall |-> $past(!pins_r.ras_n, 2))
      else $error("column strobe fell without row strobe low first");
   a_addr_stable_cas: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      s_cas_fall |-> $stable(pins_r.multiplexed_address))
      else $error("column address moved at column strobe fall");
   a_early_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (s_cas_fall and cur_r.write) |-> !pins_r.we_n)
      else $error("write strobe not low before column strobe");
   a_cbr_order: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $fell(pins_r.ras_n) && !pins_r.cas_n |-> $past(!pins_r.cas_n))
      else $error("column strobe not low before row strobe in refresh");
   a_powerup_high: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state_r == ST_POWERUP |-> pins_r.ras_n && pins_r.cas_n)
      else $error("strobes not high during power-up pause");
   a_refresh_served: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      $rose(ref_due_r) && state_r != ST_POWERUP |->
      ##[1:40] (state_r == ST_CBR))
      else $error("refresh not started in time");
   a_read_result: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      rvalid_r |-> $past(state_r == ST_CAS) && !cur_r.write)
      else $error("read data flagged outside a read");
   a_ras_width: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $fell(pins_r.ras_n) |-> !pins_r.ras_n [*4])
      else $error("row strobe pulse too short");
endmodule

//--- dram_model.sv
// Purpose: behavioural 1M x 1 page-mode memory facing the controller pins
// Assumes: strobes are active low; address halves arrive row then column
// Notes:   flags controller faults in err_count_o; unreleased dout shows junk
`timescale 1ns/100ps
module dram_model
   import dram_ctl_pkg::*;
#(
   parameter int PAUSE_NS   = 400,
   parameter int MAX_GAP_NS = 5000
) (
   input  wire dram_pins_t  pins_i,
   output logic             dout_o,
   output logic [15:0]      ref_count_o,
   output logic [15:0]      err_count_o
);
   logic                   mem [0:(1<<CELL_ADDR_W)-1];
   logic [ADDR_W-1:0]      row_r;
   logic [ADDR_W-1:0]      ctr_r;
   logic [CELL_ADDR_W-1:0] cell_r;
   logic                   rd_on;
   realtime                ras_t;
   realtime                ref_t;
   realtime                d;
   wire                    ras_n = pins_i.ras_n;
   wire                    cas_n = pins_i.cas_n;
   wire                    we_n  = pins_i.we_n;
   wire [ADDR_W-1:0]       addr  = pins_i.multiplexed_address;

   initial begin
      dout_o      = 1'b0;
      ref_count_o = 16'h0000;
      err_count_o = 16'h0000;
      ctr_r       = '0;
      rd_on       = 1'b0;
      ref_t       = 0;
   end

   always @(negedge ras_n) begin
      ras_t = $realtime;
      if ($realtime < PAUSE_NS) err_count_o++;
      if (cas_n === 1'b0) begin
         if (ref_count_o >= INIT_CYCLES && $realtime - ref_t > MAX_GAP_NS)
            err_count_o++;
         ref_t = $realtime;
         ctr_r = ctr_r + 1'b1;
         ref_count_o++;
      end else begin
         row_r = addr;
         if (ref_count_o < INIT_CYCLES) err_count_o++;
         #(T_RAH_NS);
         if (addr !== row_r) err_count_o++;
      end
   end

   always @(negedge cas_n) begin
      if (ras_n === 1'b0) begin
         cell_r = {row_r, addr};
         if (we_n === 1'b0) begin
            mem[cell_r] = pins_i.din;
            rd_on = 1'b0;
         end else begin
            rd_on  = 1'b1;
            dout_o = ~mem[cell_r];
            d = ras_t + T_RAC_NS - $realtime;
            if (d < T_CAS_NS) d = T_CAS_NS;
            #(d);
            if (rd_on && cas_n === 1'b0) dout_o = mem[cell_r];
         end
      end
   end

   // late write strobe: data taken here and output left invalid
   always @(negedge we_n) begin
      if (ras_n === 1'b0 && cas_n === 1'b0) begin
         mem[cell_r] = pins_i.din;
         dout_o      = ~dout_o;
      end
   end

   always @(posedge cas_n) begin
      if (rd_on) begin
         rd_on  = 1'b0;
         dout_o = ~dout_o;
      end
   end
endmodule

//--- tb.sv
// Purpose: self-checking bench for the page-mode memory controller
// Assumes: shortened power-up and refresh counts
// Notes:   inputs change on falling edges only
`timescale 1ns/100ps
module tb;
   import dram_ctl_pkg::*;
   localparam int PWR_CYC = 20;
   localparam int REF_CYC = 200;
   logic        ref_clk_i;
   logic        rst_i;
   mem_req_t    req_i;
   logic        req_valid_i;
   logic        req_ready_o;
   logic        rdata_o;
   logic        rdata_valid_o;
   dram_pins_t  pins_o;
   logic        dout_i;
   logic [15:0] ref_count;
   logic [15:0] err_count;
   int          fail_count;
   int          n_checks;

   dram_ctl #(.POWERUP_CYCLES(PWR_CYC), .REF_CYCLES(REF_CYC)) dram_ctl_i (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
      .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
      .pins_o(pins_o), .dout_i(dout_i));
   dram_model #(.PAUSE_NS(PWR_CYC * 20), .MAX_GAP_NS((REF_CYC + 40) * 20))
      dram_model_i (.pins_i(pins_o), .dout_o(dout_i),
      .ref_count_o(ref_count), .err_count_o(err_count));

   always #10 ref_clk_i = ~ref_clk_i;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic do_req(input logic wr, input logic [19:0] a,
                         input logic wd, output logic rb);
      int n;
      n = 0;
      while (req_ready_o !== 1'b1 && n < 2000) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk(n < 2000, 1);
      req_i       = '{write: wr, page: 1'b0, addr: a, wdata: wd};
      req_valid_i = 1'b1;
      @(negedge ref_clk_i);
      req_valid_i = 1'b0;
      rb          = 1'bx;
      if (!wr) begin
         n = 0;
         while (rdata_valid_o !== 1'b1 && n < 40) begin
            @(negedge ref_clk_i);
            n++;
         end
         chk(n < 40, 1);
         rb = rdata_o;
      end
   endtask

   task automatic t_powerup;
      int n;
      chk({pins_o.ras_n, pins_o.cas_n, req_ready_o}, 3'h6);
      @(negedge ref_clk_i);
      rst_i = 1'b0;
      n = 0;
      while (pins_o.cas_n === 1'b1 && n < 5000) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk(n >= PWR_CYC, 1);
      n = 0;
      while (req_ready_o !== 1'b1 && n < 2000) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk(ref_count, INIT_CYCLES);
      $display("powerup test done");
   endtask

   task automatic t_rw_table;
      logic [19:0] a [6] = '{20'h00000, 20'hFFFFF, 20'h003FF, 20'hFFC00,
                             20'h5A5A5, 20'hA5A5A};
      logic        rb;
      for (int i = 0; i < 6; i++) do_req(1'b1, a[i], i[0], rb);
      for (int i = 0; i < 6; i++) begin
         do_req(1'b0, a[i], 1'b0, rb);
         chk(rb, i[0]);
      end
      do_req(1'b1, a[0], 1'b1, rb);
      do_req(1'b1, a[0], 1'b0, rb);
      do_req(1'b1, a[5], 1'b0, rb);
      do_req(1'b0, a[0], 1'b1, rb);
      chk(rb, 1'b0);
      do_req(1'b0, a[5], 1'b1, rb);
      chk(rb, 1'b0);
      do_req(1'b0, a[5], 1'b1, rb);
      chk(rb, 1'b0);
      $display("read write test done");
   endtask

   task automatic t_refresh;
      logic [15:0] start;
      start = ref_count;
      repeat (4 * REF_CYC) @(negedge ref_clk_i);
      chk(ref_count - start >= 3, 1);
      chk(err_count, 0);
      $display("refresh test done");
   endtask

   task automatic test_done;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      ref_clk_i   = 1'b0;
      rst_i       = 1'b1;
      req_i       = '0;
      req_valid_i = 1'b0;
      fail_count  = 0;
      n_checks    = 0;
      @(negedge ref_clk_i);
      t_powerup;
      t_rw_table;
      t_refresh;
      test_done;
   end

   initial begin
      #(20000 * 20);
      fail_count++;
      test_done;
   end
endmodule
